/* rtl/tcmp_timer.sv */
// Top of the sixteen-bit timer with one compare channel
// What this block and the CPU using it do
// R1: One shared temporary high byte register
// R2: Low byte write loads temp and low
// R3: Counter low read copies high to temp
// R4: Compare value reads bypass the temporary byte
// R5: CPU writes high first, reads low first
// R6: CPU masks interrupts around two-byte accesses
// R7: CPU may reuse one high byte write
// R8: Counter high location maps to temp
// R9: Clock select zero stops the counter
// R10: Each tick increments or clears counter
// R11: Counter accessible with or without ticks
// R12: CPU counter write beats count or clear
// R13: Match sets compare flag at next tick
// R14: Compare request when flag, enable and global flag set
// R15: Servicing clears the compare flag
// R16: Writing one clears compare flag
// R17: Counter write blocks next tick's match
// R18: Control B read and written directly
// R19: Tick comes only from internal prescaler
// R20: Select codes: stop,1,8,32,64,128,256,1024
// R21: Clear on compare zeroes counter after match
// R22: Overflow flag set, cleared by service/write
// R23: Overflow request needs enable, global, flag
// R24: Overflow is 0xffff wrapping to zero
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_defines.svh"
module tcmp_timer
  import tcmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tcmp_pkg::tcmp_bus_t bus,
  input wire tcmp_pkg::tcmp_ack_t ack,
  input wire logic global_irq_enable,
  output logic [7:0] rdata,
  output logic compare_irq_a,
  output logic overflow_irq
);
  import tcmp_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] counter_value; // Running count
  logic [15:0] compare_value_a; // Compare target
  logic [7:0] temp_high; // Shared temporary high byte
  logic [7:0] control_b; // Clear-on-compare and clock select
  logic compare_flag_a; // Sticky compare flag
  logic overflow_flag; // Sticky overflow flag
  logic compare_irq_enable_a; // Compare interrupt enable
  logic overflow_irq_enable; // Overflow interrupt enable
  logic ctc_pending; // Clear due one cycle after a match
  // Next values of the registers above
  logic [15:0] next_counter_value;
  logic [15:0] next_compare_value_a;
  logic [7:0] next_temp_high;
  logic [7:0] next_control_b;
  logic next_compare_flag_a;
  logic next_overflow_flag;
  logic next_compare_irq_enable_a;
  logic next_overflow_irq_enable;
  logic next_ctc_pending;
  logic [7:0] next_rdata;
  logic next_compare_irq_a;
  logic next_overflow_irq;
  logic timer_tick; // Selected tick pulse
  logic match_event; // Unblocked match on a tick
  logic cnt_write; // CPU writes counter low byte
  logic ovf_event; // Wrap from all ones
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  // Prescaler picks the tick from the clock select field
  tcmp_prescaler u_pre (
    .clk(clk),
    .rst_b(rst_b),
    .clock_select(control_b[2:0]),
    .timer_tick(timer_tick)
  );
  // Comparator, with the match blocked after a counter write
  tcmp_compare u_cmp (
    .clk(clk),
    .rst_b(rst_b),
    .counter_value(counter_value),
    .compare_value_a(compare_value_a),
    .timer_tick(timer_tick),
    .cnt_write(cnt_write),
    .match_event(match_event)
  );
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One process works out every next value of the block
  always_comb
  begin
    // Counter low write, the trigger of a sixteen-bit counter load
    cnt_write = bus.wr && (bus.addr == `TCMP_ADDR_CNT_LOW);
    // Hold the counter, compare, temp, control and enable registers unless a branch below moves them
    next_counter_value = counter_value;
    next_compare_value_a = compare_value_a;
    next_temp_high = temp_high;
    next_control_b = control_b;
    next_compare_irq_enable_a = compare_irq_enable_a;
    next_overflow_irq_enable = overflow_irq_enable;
    // A match with clear on compare arms a clear for the next cycle
    next_ctc_pending = match_event && control_b[`TCMP_BIT_CTC]; // R21
    ovf_event = 1'b0;
    // Read data is zero unless a read selects a register
    next_rdata = `TCMP_BYTE_ZERO;
    // Counter update; CPU write wins
    if (cnt_write)
      next_counter_value = {temp_high, bus.wdata}; // R2 R11 R12
    else if (ctc_pending)
      next_counter_value = `TCMP_CNT_ZERO; // R21 R10
    else if (timer_tick) // R9
    begin
      next_counter_value = counter_value + `TCMP_CNT_ONE; // R10
      ovf_event = (counter_value == `TCMP_CNT_ONES); // R24
    end
    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        `TCMP_ADDR_CNT_HIGH: next_temp_high = bus.wdata; // R8 R1
        `TCMP_ADDR_CMP_HIGH: next_temp_high = bus.wdata; // R1
        `TCMP_ADDR_CMP_LOW: next_compare_value_a = {temp_high, bus.wdata}; // R2
        `TCMP_ADDR_CTRL_B: next_control_b = bus.wdata & `TCMP_CTRL_MASK; // R18
        `TCMP_ADDR_MASK:
        begin
          next_compare_irq_enable_a = bus.wdata[`TCMP_BIT_CMPA];
          next_overflow_irq_enable = bus.wdata[`TCMP_BIT_OVF];
        end
        default: next_temp_high = temp_high; // Counter low and flag writes handled elsewhere, address 7 ignored
      endcase
    end
    // Register reads
    if (bus.rd)
    begin
      case (bus.addr)
        `TCMP_ADDR_CNT_LOW:
        begin
          next_rdata = counter_value[7:0];
          next_temp_high = counter_value[15:8]; // R3
        end
        `TCMP_ADDR_CNT_HIGH: next_rdata = temp_high; // R8
        `TCMP_ADDR_CMP_LOW: next_rdata = compare_value_a[7:0]; // R4
        `TCMP_ADDR_CMP_HIGH: next_rdata = compare_value_a[15:8]; // R4
        `TCMP_ADDR_CTRL_B: next_rdata = control_b; // R18
        `TCMP_ADDR_FLAGS: next_rdata = {6'h00, compare_flag_a, overflow_flag};
        `TCMP_ADDR_MASK: next_rdata = {6'h00, compare_irq_enable_a, overflow_irq_enable};
        default: next_rdata = `TCMP_BYTE_ZERO;
      endcase
    end
    // Flags: a new event wins over any clear
    if (match_event)
      next_compare_flag_a = 1'b1; // R13
    else if (ack.ack_cmpa) // R15
      next_compare_flag_a = 1'b0;
    else if (bus.wr && bus.addr == `TCMP_ADDR_FLAGS && bus.wdata[`TCMP_BIT_CMPA]) // R16
      next_compare_flag_a = 1'b0;
    else
      next_compare_flag_a = compare_flag_a;
    // Overflow flag: a wrap wins over any clear
    if (ovf_event)
      next_overflow_flag = 1'b1; // R22
    else if (ack.ack_ovf || (bus.wr && bus.addr == `TCMP_ADDR_FLAGS && bus.wdata[`TCMP_BIT_OVF])) // R22
      next_overflow_flag = 1'b0;
    else
      next_overflow_flag = overflow_flag;
    // Interrupt requests
    next_compare_irq_a = next_compare_flag_a && next_compare_irq_enable_a && global_irq_enable; // R14
    next_overflow_irq = next_overflow_flag && next_overflow_irq_enable && global_irq_enable; // R23
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Only registers the next values; reset clears everything
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Every register and output starts at zero
      counter_value <= `TCMP_CNT_ZERO;
      compare_value_a <= `TCMP_CNT_ZERO;
      temp_high <= `TCMP_BYTE_ZERO;
      control_b <= `TCMP_BYTE_ZERO;
      compare_flag_a <= 1'b0;
      overflow_flag <= 1'b0;
      compare_irq_enable_a <= 1'b0;
      overflow_irq_enable <= 1'b0;
      ctc_pending <= 1'b0;
      rdata <= `TCMP_BYTE_ZERO;
      compare_irq_a <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      // Take the next values
      counter_value <= next_counter_value;
      compare_value_a <= next_compare_value_a;
      temp_high <= next_temp_high;
      control_b <= next_control_b;
      compare_flag_a <= next_compare_flag_a;
      overflow_flag <= next_overflow_flag;
      compare_irq_enable_a <= next_compare_irq_enable_a;
      overflow_irq_enable <= next_overflow_irq_enable;
      ctc_pending <= next_ctc_pending;
      rdata <= next_rdata;
      compare_irq_a <= next_compare_irq_a;
      overflow_irq <= next_overflow_irq;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // All checks use the system clock and rest during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Low byte write loads the pair in one cycle
  chk_low_write_load: assert property (cnt_write |=> counter_value == {$past(temp_high), $past(bus.wdata)}) // R2
    else $error("counter low write did not load both bytes");
  // Write of the counter high location only reaches the temporary byte
  chk_high_to_temp: assert property (bus.wr && bus.addr == `TCMP_ADDR_CNT_HIGH // R8
    |=> temp_high == $past(bus.wdata))
    else $error("counter high write missed the temporary byte");
  // Read of the counter high location returns the temporary byte
  chk_high_read_temp: assert property (bus.rd && bus.addr == `TCMP_ADDR_CNT_HIGH && !bus.wr // R8
    |=> rdata == $past(temp_high))
    else $error("counter high read did not return the temporary byte");
  // Low byte read snapshots the high byte
  chk_read_copy_temp: assert property (bus.rd && bus.addr == `TCMP_ADDR_CNT_LOW && !bus.wr // R3
    |=> temp_high == $past(counter_value[15:8]) && rdata == $past(counter_value[7:0]))
    else $error("counter low read did not capture high byte");
  // A compare high byte read leaves the temporary byte alone
  chk_cmp_read_direct: assert property (bus.rd && bus.addr == `TCMP_ADDR_CMP_HIGH && !bus.wr // R4
    |=> rdata == $past(compare_value_a[15:8]) && $stable(temp_high))
    else $error("compare read disturbed temp or wrong data");
  // Control register reads back whole, reserved bits zero
  chk_ctrl_readback: assert property (bus.rd && bus.addr == `TCMP_ADDR_CTRL_B && !bus.wr // R18
    |=> rdata == $past(control_b) && rdata[7:4] == 4'h0)
    else $error("control register read back wrong");
  // No tick at all while no clock is selected
  chk_stop_no_tick: assert property (control_b[2:0] == `TCMP_CS_STOP |-> !timer_tick) // R9
    else $error("tick while no clock selected");
  // A stopped counter holds unless written or cleared
  chk_stopped_hold: assert property (control_b[2:0] == `TCMP_CS_STOP && !cnt_write && !ctc_pending // R9
    |=> $stable(counter_value))
    else $error("counter moved while stopped");
  // Each free tick adds one
  chk_tick_incr: assert property (timer_tick && !cnt_write && !ctc_pending // R10
    |=> counter_value == $past(counter_value) + `TCMP_CNT_ONE)
    else $error("counter did not increment on tick");
  // Counter write beats a tick or a pending clear
  chk_write_priority: assert property (cnt_write && (timer_tick || ctc_pending) // R12
    |=> counter_value == {$past(temp_high), $past(bus.wdata)})
    else $error("count or clear overrode a counter write");
  // An unblocked match sets the flag
  chk_match_flag: assert property (match_event |=> compare_flag_a) // R13
    else $error("match did not set compare flag");
  // A tick in the cycle right after a counter write never matches
  chk_block_write: assert property (cnt_write ##1 (!cnt_write && timer_tick) |-> !match_event) // R17
    else $error("match not blocked after counter write");
  // Clear on compare zeroes the counter two cycles after the match
  chk_ctc_clear: assert property (match_event && control_b[`TCMP_BIT_CTC] ##1 !cnt_write // R21
    |=> counter_value == `TCMP_CNT_ZERO)
    else $error("clear on compare failed");
  // Compare request follows flag, enable and the global flag
  chk_cmp_irq: assert property (compare_irq_a // R14
    == ($past(global_irq_enable) && compare_flag_a && compare_irq_enable_a))
    else $error("compare request does not follow flag and enables");
  // Service clears the compare flag unless a match lands
  chk_cmp_ack_clear: assert property (ack.ack_cmpa && !match_event |=> !compare_flag_a) // R15
    else $error("service did not clear compare flag");
  // Writing one clears the compare flag
  chk_cmp_write_clear: assert property (bus.wr && bus.addr == `TCMP_ADDR_FLAGS // R16
    && bus.wdata[`TCMP_BIT_CMPA] && !match_event |=> !compare_flag_a)
    else $error("write of one did not clear compare flag");
  // Wrap from all ones raises the overflow flag
  chk_ovf_set: assert property (timer_tick && !cnt_write && !ctc_pending // R22 R24
    && counter_value == `TCMP_CNT_ONES |=> overflow_flag)
    else $error("overflow not flagged");
  // Service or a write of one clears the overflow flag
  chk_ovf_clear: assert property ((ack.ack_ovf || (bus.wr && bus.addr == `TCMP_ADDR_FLAGS // R22
    && bus.wdata[`TCMP_BIT_OVF])) && !ovf_event |=> !overflow_flag)
    else $error("overflow flag not cleared");
  // Overflow request needs flag, enable and the global flag
  chk_ovf_irq: assert property (overflow_irq // R23
    == ($past(global_irq_enable) && overflow_flag && overflow_irq_enable))
    else $error("overflow request does not follow flag and enables");
  // Read data stands one cycle, then returns to zero
  chk_rdata_idle: assert property (!bus.rd |=> rdata == `TCMP_BYTE_ZERO)
    else $error("read data not zero without a read");
  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  // Match, wrap, clear on compare, blocked tick and a flag clear
  cov_match: cover property (match_event);
  cov_overflow: cover property (ovf_event);
  cov_ctc: cover property (ctc_pending);
  cov_blocked: cover property (cnt_write ##1 timer_tick);
  cov_flag_clear: cover property (compare_flag_a ##1 !compare_flag_a);
endmodule
`default_nettype wire

/* common/tcmp_defines.svh */
// Constants for the sixteen-bit compare timer
`ifndef TCMP_DEFINES_SVH
`define TCMP_DEFINES_SVH
`define TCMP_ADDR_CNT_LOW 3'h0
`define TCMP_ADDR_CNT_HIGH 3'h1
`define TCMP_ADDR_CMP_LOW 3'h2
`define TCMP_ADDR_CMP_HIGH 3'h3
`define TCMP_ADDR_CTRL_B 3'h4
`define TCMP_ADDR_FLAGS 3'h5
`define TCMP_ADDR_MASK 3'h6
`define TCMP_CS_STOP 3'h0
`define TCMP_CS_DIV1 3'h1
`define TCMP_CS_DIV8 3'h2
`define TCMP_CS_DIV32 3'h3
`define TCMP_CS_DIV64 3'h4
`define TCMP_CS_DIV128 3'h5
`define TCMP_CS_DIV256 3'h6
`define TCMP_CS_DIV1024 3'h7
`define TCMP_PRE_MAX 10'h3ff
`define TCMP_TAP8 10'h007
`define TCMP_TAP32 10'h01f
`define TCMP_TAP64 10'h03f
`define TCMP_TAP128 10'h07f
`define TCMP_TAP256 10'h0ff
`define TCMP_TAP1024 10'h3ff
`define TCMP_CNT_ZERO 16'h0000
`define TCMP_CNT_ONES 16'hffff
`define TCMP_CNT_ONE 16'h0001
`define TCMP_BYTE_ZERO 8'h00
`define TCMP_BIT_OVF 0
`define TCMP_BIT_CMPA 1
`define TCMP_BIT_CTC 3
`define TCMP_CTRL_MASK 8'h0f
`endif

/* common/tcmp_pkg.sv */
// Types for the sixteen-bit compare timer
package tcmp_pkg;
  // One CPU bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tcmp_bus_t;
  // Interrupt acknowledges from the CPU
  typedef struct packed {
    logic ack_ovf;
    logic ack_cmpa;
  } tcmp_ack_t;
endpackage

/* rtl/tcmp_prescaler.sv */
// Free running prescaler with tick selection
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_defines.svh"
module tcmp_prescaler
  import tcmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] clock_select,
  output logic timer_tick
);
  // ----------------------------------------
  // Prescaler counter
  // ----------------------------------------
  logic [9:0] pre; // Free running count
  logic [9:0] next_pre;
  always_comb
  begin
    next_pre = pre + 10'h001;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pre <= 10'h000;
    else
      pre <= next_pre;
  end
  // ----------------------------------------
  // Tick selection (combinational pulse)
  // ----------------------------------------
  always_comb
  begin
    case (clock_select) // R20
      `TCMP_CS_STOP: timer_tick = 1'b0; // R9
      `TCMP_CS_DIV1: timer_tick = 1'b1; // R19
      `TCMP_CS_DIV8: timer_tick = ((pre & `TCMP_TAP8) == `TCMP_TAP8);
      `TCMP_CS_DIV32: timer_tick = ((pre & `TCMP_TAP32) == `TCMP_TAP32);
      `TCMP_CS_DIV64: timer_tick = ((pre & `TCMP_TAP64) == `TCMP_TAP64);
      `TCMP_CS_DIV128: timer_tick = ((pre & `TCMP_TAP128) == `TCMP_TAP128);
      `TCMP_CS_DIV256: timer_tick = ((pre & `TCMP_TAP256) == `TCMP_TAP256);
      default: timer_tick = (pre == `TCMP_TAP1024);
    endcase
  end
endmodule
`default_nettype wire

/* rtl/tcmp_compare.sv */
// Compare unit with match blocking after a counter write
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_defines.svh"
module tcmp_compare
  import tcmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_value_a,
  input wire logic timer_tick,
  input wire logic cnt_write,
  output logic match_event
);
  // ----------------------------------------
  // Block latch for counter writes
  // ----------------------------------------
  logic block; // Suppress the match of the next tick
  logic next_block;
  logic equal;
  always_comb
  begin
    equal = (counter_value == compare_value_a); // R13
    if (cnt_write)
      next_block = 1'b1; // R17
    else if (timer_tick)
      next_block = 1'b0;
    else
      next_block = block;
    match_event = timer_tick && equal && !block && !cnt_write; // R13 R17
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      block <= 1'b0;
    else
      block <= next_block;
  end
endmodule
`default_nettype wire

/* testbench/tcmp_cpu_model.sv */
// CPU side model that services timer interrupt requests
`timescale 1ns/1ps
`default_nettype none
module tcmp_cpu_model
  import tcmp_pkg::*;
#(
  parameter int LATENCY = 3
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serve,
  input wire logic compare_irq_a,
  input wire logic overflow_irq,
  output var tcmp_pkg::tcmp_ack_t ack
);
  // Services one request after a delay, then waits three cycles before looking again
  initial
  begin
    ack = '0;
    forever
    begin
      @(negedge clk);
      // Two-byte accesses are only made while serve is low
      if (rst_b && serve && (compare_irq_a || overflow_irq))
      begin
        repeat (LATENCY) @(negedge clk);
        ack.ack_cmpa = compare_irq_a;
        ack.ack_ovf = overflow_irq & ~compare_irq_a;
        @(negedge clk);
        ack = '0;
        repeat (3) @(negedge clk);
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_tcmp_timer.sv */
// Self-checking bench for the sixteen-bit compare timer
`timescale 1ns/1ps
`default_nettype none
module tb_tcmp_timer;
  import tcmp_pkg::*;
  logic clk = 1'b0; // 40 MHz clock
  logic rst_b = 1'b0; // Reset, active low
  tcmp_bus_t bus = '0; // CPU access
  tcmp_ack_t ack; // Service pulses from the model
  logic global_irq_enable = 1'b0; // CPU global flag
  logic serve = 1'b0; // Lets the model service requests
  logic [7:0] rdata;
  logic compare_irq_a;
  logic overflow_irq;
  logic [7:0] rv; // Last byte read
  logic [15:0] v; // Last counter read
  int fail_count = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  tcmp_timer tcmp_timer_inst (.clk(clk), .rst_b(rst_b), .bus(bus), .ack(ack),
    .global_irq_enable(global_irq_enable), .rdata(rdata), .compare_irq_a(compare_irq_a),
    .overflow_irq(overflow_irq));
  tcmp_cpu_model tcmp_cpu_model_inst (.clk(clk), .rst_b(rst_b), .serve(serve),
    .compare_irq_a(compare_irq_a), .overflow_irq(overflow_irq), .ack(ack));
  // Byte compare
  task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // Counter compare against a window, phase of the prescaler is free
  task automatic check_range(input string s, input logic [15:0] lo, input logic [15:0] hi);
    n_checks++;
    if ($isunknown(v) || v < lo || v > hi)
    begin
      fail_count++;
      $display("unexpected %s: expected %h..%h seen %h", s, lo, hi, v);
    end
  endtask
  // One write cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = {1'b0, 1'b1, a, d};
    @(negedge clk);
    bus = '0;
  endtask
  // One read cycle, data sampled the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(negedge clk);
    bus = {1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    rv = rdata;
    bus = '0;
  endtask
  // Sixteen-bit write, high byte first
  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a + 3'h1, d[15:8]);
    wr(a, d[7:0]);
  endtask
  // Counter read, low byte first
  task automatic rd_cnt();
    rd(3'h0);
    v[7:0] = rv;
    rd(3'h1);
    v[15:8] = rv;
  endtask
  // Runs the timer with a control value for n cycles, then stops it
  task automatic run(input logic [3:0] c, input int n);
    wr(3'h4, {4'h0, c});
    repeat (n) @(negedge clk);
    wr(3'h4, {4'h0, c[3], 3'h0});
  endtask
  task automatic t_access();
    wr16(3'h0, 16'h01ff);
    wr(3'h1, 8'h55);
    rd(3'h0);
    check("cnt low", 8'hff, rv);
    rd(3'h1);
    check("cnt high", 8'h01, rv);
    wr16(3'h2, 16'h1234);
    wr(3'h1, 8'h55);
    rd(3'h2);
    check("cmp low", 8'h34, rv);
    rd(3'h3);
    check("cmp high", 8'h12, rv);
    rd(3'h1);
    check("temp kept", 8'h55, rv);
    wr(3'h1, 8'hab);
    wr(3'h0, 8'h01);
    wr(3'h2, 8'h02);
    rd_cnt();
    check_range("cnt", 16'hab01, 16'hab01);
    rd(3'h3);
    check("cmp high", 8'hab, rv);
    wr(3'h3, 8'h77);
    wr(3'h0, 8'h00);
    rd_cnt();
    check_range("cnt", 16'h7700, 16'h7700);
    wr(3'h4, 8'hff);
    rd(3'h4);
    check("ctrl", 8'h0f, rv);
    wr(3'h7, 8'hff);
    rd(3'h7);
    check("unmapped", 8'h00, rv);
  endtask
  task automatic t_prescale();
    int dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
    wr16(3'h0, 16'h0000);
    run(4'h0, 50);
    rd_cnt();
    check_range("stopped", 16'h0000, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      wr16(3'h0, 16'h0000);
      run(4'(i + 1), 8 * dv[i]);
      rd_cnt();
      check_range("ticks", 16'h0007, 16'h000a);
    end
    wr(3'h4, 8'h01);
    wr16(3'h0, 16'h4000);
    wr(3'h4, 8'h00);
    rd_cnt();
    check_range("cnt write", 16'h4000, 16'h4002);
  endtask
  task automatic t_compare();
    wr(3'h5, 8'h03);
    wr16(3'h2, 16'h00f0);
    wr16(3'h0, 16'h00f0);
    wr(3'h6, 8'h02);
    rd(3'h6);
    check("mask", 8'h02, rv);
    run(4'h1, 20);
    rd(3'h5);
    check("flags", 8'h00, rv);
    wr16(3'h0, 16'h00ee);
    run(4'h1, 20);
    rd(3'h5);
    check("flags", 8'h02, rv);
    check("cmp irq", 8'h00, {7'h0, compare_irq_a});
    global_irq_enable = 1'b1;
    repeat (3) @(negedge clk);
    check("cmp irq", 8'h01, {7'h0, compare_irq_a});
    wr(3'h5, 8'h00);
    rd(3'h5);
    check("flags", 8'h02, rv);
    wr(3'h5, 8'h02);
    rd(3'h5);
    check("flags", 8'h00, rv);
    wr16(3'h0, 16'h00ee);
    run(4'h1, 20);
    serve = 1'b1;
    repeat (12) @(negedge clk);
    serve = 1'b0;
    rd(3'h5);
    check("flags", 8'h00, rv);
    wr16(3'h2, 16'h0003);
    wr16(3'h0, 16'h0000);
    run(4'h9, 40);
    rd_cnt();
    check_range("clear", 16'h0000, 16'h0003);
  endtask
  task automatic t_overflow();
    global_irq_enable = 1'b0;
    wr16(3'h2, 16'h8000);
    wr(3'h5, 8'h03);
    wr(3'h6, 8'h01);
    wr16(3'h0, 16'hfffe);
    run(4'h1, 10);
    rd(3'h5);
    check("flags", 8'h01, rv);
    check("ovf irq", 8'h00, {7'h0, overflow_irq});
    global_irq_enable = 1'b1;
    repeat (3) @(negedge clk);
    check("ovf irq", 8'h01, {7'h0, overflow_irq});
    wr(3'h6, 8'h00);
    repeat (3) @(negedge clk);
    check("ovf irq", 8'h00, {7'h0, overflow_irq});
    wr(3'h6, 8'h01);
    serve = 1'b1;
    repeat (14) @(negedge clk);
    serve = 1'b0;
    rd(3'h5);
    check("flags", 8'h00, rv);
    wr16(3'h0, 16'hfffe);
    run(4'h1, 10);
    rd(3'h5);
    check("flags", 8'h01, rv);
    wr(3'h5, 8'h01);
    rd(3'h5);
    check("flags", 8'h00, rv);
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_access();
    t_prescale();
    t_compare();
    t_overflow();
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #(60000 * 25);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
